/* hdl/rx_fifo_regs.svh */
// Register offsets, field positions and reset values of the receive FIFO
`ifndef RX_FIFO_REGS_SVH
`define RX_FIFO_REGS_SVH
`define RF_ADDR_FIFO_SIZE  4'h0
`define RF_ADDR_CHAN_SEL   4'h1
`define RF_ADDR_ACC_VALUE  4'h2
`define RF_ADDR_ACC_MASK   4'h3
`define RF_ADDR_REJ_VALUE  4'h4
`define RF_ADDR_REJ_MASK   4'h5
`define RF_ADDR_STATUS     4'h6
`define RF_ADDR_IRQ_EN     4'h7
`define RF_ADDR_LOCK       4'h8
`define RF_ADDR_ENTRY      4'h9
`define RF_ADDR_BUF_SEL    4'ha
`define RF_ADDR_BUF_CTRL   4'hb
`define RF_MAX_BUFFERS     6'd59
`define RF_SIZE_RESET      6'h00
`define RF_BIT_NONEMPTY    0
`define RF_BIT_OVERRUN     1
`define RF_BIT_LOCK        0
`define RF_CTRL_CLEAR      16'h0000
`endif

/* hdl/rx_fifo_pkg.sv */
// Types of the receive FIFO
package rx_fifo_pkg;
   typedef struct packed {
      logic        valid;
      logic        null_frame;
      logic        error;
      logic        chan_b;
      logic        static_seg;
      logic        dedicated_hit;
      logic [10:0] frame_id;
      logic [15:0] payload;
      logic [15:0] slot_status;
   } rx_frame_t;
   typedef struct packed {
      logic [15:0] payload;
      logic [15:0] slot_status;
      logic [10:0] frame_id;
   } fifo_entry_t;
   typedef enum logic [2:0] {
      st_idle  = 3'b001,
      st_hold_a = 3'b010,
      st_drain_b = 3'b100
   } store_state_t;
endpackage

/* hdl/rx_fifo.sv */
// Receive FIFO ring with filters, indices, flags and a lock handshake
`include "rx_fifo_regs.svh"

// How it works
// - Ring starts at buffer 0, spans a set number of buffers, at most 59.
// - Unfiltered frames passing FIFO filters are stored with slot status.
// - Not-empty and overrun flags drive the interrupt when enabled.
// - Null and invalid frames are never stored.
// - Static segment, two channels: channel A frame first, then B.
// - Store at write index, then step by one, wrapping to 0.
// - Read index names the next entry and steps on each unlock.
// - Ring full drops frames; overrun set at frame end if error free.
// - Not-empty shows whenever the ring holds an entry.
// - Write and read indices have no host access.
// - Host locks buffer 0, reads the entry at read index, then unlocks.
// - Acceptance filter compares ID to value; mask bits are don't-care.
// - Rejection filter compares ID to its value with its own mask.
// - Channel select decides from which channels frames are stored.
// - A frame hit by both filters is rejected.
// - Configuration state never clears contents or indices.
// - First configuration entry zeroes all FIFO buffer control words.
module rx_fifo
   import rx_fifo_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire rx_frame_t   i_frame,
   input  wire logic        i_config_state,
   output logic             o_irq
);
   localparam int unsigned NBUF = 59;

   fifo_entry_t  mem_q [NBUF];
   logic [15:0]  ctrl_q [NBUF];
   logic [5:0]   size_q;
   logic [1:0]   chan_sel_q;
   logic [10:0]  acc_val_q;
   logic [10:0]  acc_mask_q;
   logic [10:0]  rej_val_q;
   logic [10:0]  rej_mask_q;
   logic [1:0]   irq_en_q;
   logic         nonempty_flag_q;
   logic         overrun_flag_q;
   logic         lock_q;
   logic [5:0]   buf_sel_q;
   logic [5:0]   fifo_write_index_q;
   logic [5:0]   fifo_read_index_q;
   logic [6:0]   count_q;
   logic         cfg_seen_q;
   logic         cfg_prev_q;
   rx_frame_t    held_b_q;
   store_state_t state_q;
   store_state_t state_d;
   logic         ack_q;
   logic [31:0]  rdata_q;

   // Next ring position with wrap at the configured top
   function automatic logic [5:0] ring_next(input logic [5:0] idx,
                                            input logic [5:0] size);
      logic [5:0] top;
      top = (size == 6'h00) ? 6'h00 : size - 6'h01;
      ring_next = (idx >= top) ? 6'h00 : idx + 6'h01;
   endfunction

   // Masked identifier compare, set mask bits ignored
   function automatic logic id_match(input logic [10:0] id,
                                     input logic [10:0] val,
                                     input logic [10:0] mask);
      id_match = ((id ^ val) & ~mask) == 11'h000;
   endfunction

   // Filter verdict for one frame
   function automatic logic passes(input rx_frame_t f,
                                   input logic [1:0] chan,
                                   input logic [10:0] av,
                                   input logic [10:0] am,
                                   input logic [10:0] rv,
                                   input logic [10:0] rm);
      logic on_chan;
      on_chan = f.chan_b ? chan[1] : chan[0];
      passes = f.valid && !f.null_frame && !f.error
             && !f.dedicated_hit && on_chan
             && id_match(f.frame_id, av, am)
             && !id_match(f.frame_id, rv, rm);
   endfunction

   wire       bus_req     = (i_avs_read || i_avs_write) && !ack_q;
   // Writes land at the edge where waitrequest is low
   wire       wr_req      = i_avs_write && ack_q;
   wire       sel_size    = i_avs_address == `RF_ADDR_FIFO_SIZE;
   wire       sel_chan    = i_avs_address == `RF_ADDR_CHAN_SEL;
   wire       sel_accv    = i_avs_address == `RF_ADDR_ACC_VALUE;
   wire       sel_accm    = i_avs_address == `RF_ADDR_ACC_MASK;
   wire       sel_rejv    = i_avs_address == `RF_ADDR_REJ_VALUE;
   wire       sel_rejm    = i_avs_address == `RF_ADDR_REJ_MASK;
   wire       sel_stat    = i_avs_address == `RF_ADDR_STATUS;
   wire       sel_irqen   = i_avs_address == `RF_ADDR_IRQ_EN;
   wire       sel_lock    = i_avs_address == `RF_ADDR_LOCK;
   wire       sel_bsel    = i_avs_address == `RF_ADDR_BUF_SEL;
   wire       sel_bctl    = i_avs_address == `RF_ADDR_BUF_CTRL;
   wire       sel_entry   = i_avs_address == `RF_ADDR_ENTRY;
   wire       lock_wr     = wr_req && sel_lock
                            && i_avs_writedata[`RF_BIT_LOCK];
   wire       unlock_ev   = lock_wr && lock_q && count_q != 7'h00;
   wire       first_cfg   = i_config_state && !cfg_prev_q && !cfg_seen_q;
   wire       frame_ok    = passes(i_frame, chan_sel_q, acc_val_q,
                                   acc_mask_q, rej_val_q, rej_mask_q);
   wire       pass_b      = passes(held_b_q, chan_sel_q, acc_val_q,
                                   acc_mask_q, rej_val_q, rej_mask_q);
   // Channel B frames in the static segment wait for the A frame slot
   wire       defer_b     = i_frame.valid && i_frame.chan_b
                            && state_q == st_hold_a;
   wire       store_a     = frame_ok && !defer_b
                            && state_q != st_drain_b;
   wire       store_b     = state_q == st_drain_b && pass_b;
   wire       store_req   = store_a || store_b;
   wire       full        = count_q >= {1'b0, size_q};
   wire       do_store    = store_req && !full && size_q != 6'h00;
   wire       overrun_ev  = store_req && full;
   wire       read_step   = unlock_ev;
   wire fifo_entry_t new_entry = store_b
      ? {held_b_q.payload, held_b_q.slot_status, held_b_q.frame_id}
      : {i_frame.payload, i_frame.slot_status, i_frame.frame_id};
   wire fifo_entry_t cur_entry = mem_q[fifo_read_index_q];
   wire       bsel_ok     = buf_sel_q < 6'(NBUF);
   wire [15:0] bctl_rd    = bsel_ok ? ctrl_q[buf_sel_q] : 16'h0000;

   // Two-channel ordering: a B frame seen in st_hold_a, after a static A frame, waits one cycle
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         st_idle:
            if (i_frame.valid && i_frame.static_seg && !i_frame.chan_b)
               state_d = st_hold_a;
         st_hold_a:
            if (i_frame.valid && i_frame.chan_b)
               state_d = st_drain_b;
            else if (!i_frame.static_seg)
               state_d = st_idle;
         st_drain_b:
            state_d = st_idle;
         default:
            state_d = st_idle;
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_q  <= st_idle;
         held_b_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         if (state_q == st_hold_a && i_frame.valid && i_frame.chan_b)
            held_b_q <= i_frame;
      end
   end

   // Ring storage; configuration state leaves it untouched
   always_ff @(posedge i_clock)
   begin
      if (do_store)
         mem_q[fifo_write_index_q] <= new_entry;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         fifo_write_index_q <= 6'h00;
         fifo_read_index_q  <= 6'h00;
         count_q            <= 7'h00;
      end
      else
      begin
         if (do_store)
            fifo_write_index_q <= ring_next(fifo_write_index_q,
                                            size_q);
         if (read_step)
            fifo_read_index_q <= ring_next(fifo_read_index_q,
                                           size_q);
         count_q <= count_q + 7'(do_store) - 7'(read_step);
      end
   end

   // Flags: hardware set wins over a software clear
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         nonempty_flag_q <= 1'b0;
         overrun_flag_q  <= 1'b0;
      end
      else
      begin
         nonempty_flag_q <= (count_q + 7'(do_store) - 7'(read_step))
                            != 7'h00;
         if (overrun_ev)
            overrun_flag_q <= 1'b1;
         else if (wr_req && sel_stat
                  && i_avs_writedata[`RF_BIT_OVERRUN])
            overrun_flag_q <= 1'b0;
      end
   end

   // Buffer control words; zeroed once on the first configuration entry
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         cfg_seen_q <= 1'b0;
         cfg_prev_q <= 1'b0;
         for (int i = 0; i < NBUF; i++)
            ctrl_q[i] <= `RF_CTRL_CLEAR;
      end
      else
      begin
         cfg_prev_q <= i_config_state;
         if (first_cfg)
         begin
            cfg_seen_q <= 1'b1;
            for (int i = 0; i < NBUF; i++)
               ctrl_q[i] <= `RF_CTRL_CLEAR;
         end
         else if (wr_req && sel_bctl && bsel_ok)
            ctrl_q[buf_sel_q] <= i_avs_writedata[15:0];
      end
   end

   // Host-written settings and the lock handshake
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         size_q     <= `RF_SIZE_RESET;
         chan_sel_q <= 2'h3;
         acc_val_q  <= 11'h000;
         acc_mask_q <= 11'h7ff;
         rej_val_q  <= 11'h000;
         rej_mask_q <= 11'h000;
         irq_en_q   <= 2'h0;
         buf_sel_q  <= 6'h00;
         lock_q     <= 1'b0;
      end
      else if (wr_req)
      begin
         if (sel_size)
            size_q <= (i_avs_writedata[5:0] > `RF_MAX_BUFFERS)
                      ? `RF_MAX_BUFFERS : i_avs_writedata[5:0];
         if (sel_chan)
            chan_sel_q <= i_avs_writedata[1:0];
         if (sel_accv)
            acc_val_q <= i_avs_writedata[10:0];
         if (sel_accm)
            acc_mask_q <= i_avs_writedata[10:0];
         if (sel_rejv)
            rej_val_q <= i_avs_writedata[10:0];
         if (sel_rejm)
            rej_mask_q <= i_avs_writedata[10:0];
         if (sel_irqen)
            irq_en_q <= i_avs_writedata[1:0];
         if (sel_bsel)
            buf_sel_q <= i_avs_writedata[5:0];
         // Writing the lock bit toggles; lock granted only with an entry
         if (lock_wr)
            lock_q <= lock_q ? 1'b0 : (count_q != 7'h00);
      end
   end

   // Answer one cycle after the request; indices stay unmapped
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= bus_req;
         if (bus_req && i_avs_read)
         begin
            if (sel_size)
               rdata_q <= {26'h0, size_q};
            else if (sel_chan)
               rdata_q <= {30'h0, chan_sel_q};
            else if (sel_accv)
               rdata_q <= {21'h0, acc_val_q};
            else if (sel_accm)
               rdata_q <= {21'h0, acc_mask_q};
            else if (sel_rejv)
               rdata_q <= {21'h0, rej_val_q};
            else if (sel_rejm)
               rdata_q <= {21'h0, rej_mask_q};
            else if (sel_stat)
               rdata_q <= {30'h0, overrun_flag_q, nonempty_flag_q};
            else if (sel_irqen)
               rdata_q <= {30'h0, irq_en_q};
            else if (sel_lock)
               rdata_q <= {31'h0, lock_q};
            else if (sel_entry && lock_q)
               rdata_q <= {cur_entry.payload, 5'h0,
                           cur_entry.frame_id};
            else if (sel_bsel)
               rdata_q <= {26'h0, buf_sel_q};
            else if (sel_bctl)
               rdata_q <= {16'h0, bctl_rd};
            else
               rdata_q <= 32'h0000_0000;
         end
      end
   end

   assign o_avs_waitrequest = bus_req;
   assign o_avs_readdata    = rdata_q;
   assign o_irq = (nonempty_flag_q && irq_en_q[`RF_BIT_NONEMPTY])
                || (overrun_flag_q && irq_en_q[`RF_BIT_OVERRUN]);
endmodule

/* verif/rx_fifo_assertions.sv */
// Port-level checks of the receive FIFO
module rx_fifo_assertions
   import rx_fifo_pkg::*;
(
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic [3:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire rx_frame_t   i_frame,
   input wire logic        i_config_state,
   input wire logic        o_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   logic       req;
   logic       rdone;
   logic       wdone;
   logic       seen_q;
   logic [1:0] en_q;
   assign req   = i_avs_read | i_avs_write;
   assign rdone = i_avs_read & ~o_avs_waitrequest;
   assign wdone = i_avs_write & ~o_avs_waitrequest;
   // Shadow of the enables, so irq can be tied to status reads
   always_ff @(posedge i_clock or posedge i_rst)
      if (i_rst)
      begin
         en_q   <= 2'h0;
         seen_q <= 1'b0;
      end
      else
      begin
         if (wdone && i_avs_address == 4'h7)
            en_q <= i_avs_writedata[1:0];
         if (i_frame.valid)
            seen_q <= 1'b1;
      end
   a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
      else $error("No wait state on a new request");
   a_wait_second: assert property (req && o_avs_waitrequest |=>
      !o_avs_waitrequest) else $error("Wait state too long");
   a_wait_idle: assert property (!req |-> !o_avs_waitrequest)
      else $error("Wait raised without request");
   a_unmapped_zero: assert property (rdone && i_avs_address > 4'hb |->
      o_avs_readdata == 32'h0) else $error("Unmapped read not zero");
   a_rdata_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
      else $error("Read data moved without a read");
   a_irq_masked: assert property (wdone && i_avs_address == 4'h7 &&
      i_avs_writedata[1:0] == 2'h0 |=> !o_irq) else $error("Masked irq");
   a_irq_status: assert property (rdone && i_avs_address == 4'h6 |->
      o_irq == |(o_avs_readdata[1:0] & en_q)) else $error("Irq vs status");
   a_empty_start: assert property (rdone && i_avs_address == 4'h6 &&
      !seen_q |-> o_avs_readdata[1:0] == 2'h0) else $error("Flags before data");
   a_entry_blank: assert property (rdone && i_avs_address == 4'h9 &&
      !seen_q |-> o_avs_readdata == 32'h0) else $error("Entry without data");
endmodule

/* verif/rx_frame_src.sv */
// Behavioural model of the frame reception path
module rx_frame_src
   import rx_fifo_pkg::*;
(
   input  wire logic i_clock,
   output rx_frame_t o_frame
);
   timeunit 1ns;
   timeprecision 1ns;
   initial o_frame = '0;
   // k holds null, error, channel B, static and dedicated-hit marks
   task automatic send(input logic [10:0] id, input logic [4:0] k);
      @(posedge i_clock);
      o_frame <= {1'b1, k, id, 5'h0, ~id, 5'h0, id};
   endtask
   // Stale fields inverted so the simulator cannot hide a late sample
   task automatic idle();
      @(posedge i_clock);
      o_frame <= {1'b0, ~o_frame[47:0]};
   endtask
endmodule

/* verif/rx_fifo_tb.sv */
// Self-checking bench for the receive FIFO
module rx_fifo_tb
   import rx_fifo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clock = 0, i_rst = 1, rd = 0, wr = 0, cfg = 0;
   logic        wreq, irq, ovr = 0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, v;
   rx_frame_t   frame;
   logic [10:0] fq[$];
   int          fails = 0, tests_run = 0, depth = 3;
   always #5 i_clock = ~i_clock;
   rx_frame_src src (.i_clock(i_clock), .o_frame(frame));
   rx_fifo uut (.i_clock(i_clock), .i_rst(i_rst), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_frame(frame),
      .i_config_state(cfg), .o_irq(irq));
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         fails++;
      end
   endtask
   // Waitrequest and read data taken at the same rising edge
   task automatic bus(input logic [3:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clock);
      addr  <= a;
      wdata <= d;
      rd    <= ~w;
      wr    <= w;
      do
         @(posedge i_clock);
      while (wreq !== 1'b0 && ++n < 64);
      if (n >= 64)
      begin
         fails++;
         end_sim();
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e,
                       input string n);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(n, e, q);
   endtask
   task automatic rx(input logic [10:0] id, input logic [4:0] k,
                     input logic ok);
      src.send(id, k);
      src.idle();
      if (ok && fq.size() < depth)
         fq.push_back(id);
      else if (ok)
         ovr = 1'b1;
   endtask
   task automatic status();
      rchk(4'h6, {30'h0, ovr, fq.size() != 0}, "status");
   endtask
   task automatic pulse_cfg();
      @(posedge i_clock);
      cfg <= 1'b1;
      repeat (2) @(posedge i_clock);
      cfg <= 1'b0;
   endtask
   // Lock, read the oldest entry, unlock
   task automatic take();
      logic [10:0] id;
      id = fq.pop_front();
      bus(4'h8, 1'b1, 32'h1, v);
      rchk(4'h8, 32'h1, "lock");
      rchk(4'h9, {5'h0, ~id, 5'h0, id}, "entry");
      bus(4'h8, 1'b1, 32'h1, v);
   endtask
   initial
   begin
      repeat (20) @(posedge i_clock);
      i_rst <= 1'b0;
      rchk(4'h0, 32'h0, "size");
      rchk(4'h1, 32'h3, "chan select");
      rchk(4'h3, 32'h7ff, "acc mask");
      status();
      rchk(4'hf, 32'h0, "unmapped");
      rchk(4'h9, 32'h0, "entry idle");
      bus(4'h0, 1'b1, 32'h3f, v);
      rchk(4'h0, 32'd59, "size clamp");
      bus(4'ha, 1'b1, 32'h1, v);
      bus(4'hb, 1'b1, 32'hab, v);
      pulse_cfg();
      rchk(4'hb, 32'h0, "buffer ctrl");
      bus(4'hb, 1'b1, 32'h0, v);
      bus(4'h0, 1'b1, 32'h3, v);
      bus(4'h7, 1'b1, 32'h3, v);
      bus(4'h8, 1'b1, 32'h1, v);
      rchk(4'h8, 32'h0, "lock empty");
      $display("Reset and config test done");
      rx(11'h5, 5'h10, 1'b0);
      rx(11'h6, 5'h08, 1'b0);
      rx(11'h7, 5'h01, 1'b0);
      rx(11'h0, 5'h00, 1'b0);
      status();
      for (int i = 1; i < 5; i++)
         rx(11'(i), 5'h00, 1'b1);
      status();
      @(negedge i_clock);
      chk("irq", 32'h1, {31'h0, irq});
      while (fq.size() > 0)
         take();
      status();
      bus(4'h6, 1'b1, 32'h2, v);
      ovr = 1'b0;
      status();
      $display("Fill and overrun test done");
      rx(11'h8, 5'h00, 1'b1);
      rx(11'h9, 5'h00, 1'b1);
      take();
      rx(11'ha, 5'h00, 1'b1);
      rx(11'hb, 5'h00, 1'b1);
      pulse_cfg();
      while (fq.size() > 0)
         take();
      $display("Wrap and config test done");
      bus(4'h2, 1'b1, 32'h100, v);
      bus(4'h3, 1'b1, 32'h0ff, v);
      bus(4'h4, 1'b1, 32'h155, v);
      rx(11'h1aa, 5'h00, 1'b1);
      rx(11'h2aa, 5'h00, 1'b0);
      rx(11'h155, 5'h00, 1'b0);
      bus(4'h1, 1'b1, 32'h1, v);
      rx(11'h1bb, 5'h04, 1'b0);
      bus(4'h1, 1'b1, 32'h3, v);
      src.send(11'h1d1, 5'h02);
      src.send(11'h1d2, 5'h06);
      src.idle();
      fq.push_back(11'h1d1);
      fq.push_back(11'h1d2);
      while (fq.size() > 0)
         take();
      status();
      bus(4'h7, 1'b1, 32'h0, v);
      $display("Filter and channel test done");
      end_sim();
   end
endmodule
bind rx_fifo rx_fifo_assertions chk (
   .i_clock(i_clock), .i_rst(i_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_frame(i_frame),
   .i_config_state(i_config_state), .o_irq(o_irq));
